// ### rtl/isp_defs.svh
/*
 Constants of the two-channel serial audio port: register offsets, field
 positions, reset values and the timing figures of the clock generator.
 Assumes it is included once, by the package, ahead of the modules that use its macros.
*/
`ifndef ISP_DEFS_SVH
`define ISP_DEFS_SVH

// Register word addresses.
`define ISP_OFS_TASKS 4'h0
`define ISP_OFS_CONFIG 4'h1
`define ISP_OFS_MAXCNT 4'h2
`define ISP_OFS_TXLEFT 4'h3
`define ISP_OFS_TXRIGHT 4'h4
`define ISP_OFS_RXLEFT 4'h5
`define ISP_OFS_RXRIGHT 4'h6
`define ISP_OFS_EVENTS 4'h7

// Task register bits.
`define ISP_TASK_START 0
`define ISP_TASK_STOP 1

// Configuration field positions.
`define ISP_CFG_TXEN 0
`define ISP_CFG_RXEN 1
`define ISP_CFG_MCKEN 2
`define ISP_CFG_MASTER 3
`define ISP_CFG_ALIGNED 4
`define ISP_CFG_WIDTH_LO 5
`define ISP_CFG_WIDTH_HI 6
`define ISP_CFG_DIV_LO 8
`define ISP_CFG_DIV_HI 15
`define ISP_CFG_RATIO_LO 16
`define ISP_CFG_RATIO_HI 27
`define ISP_CFG_PSEL_LO 28
`define ISP_CFG_PSEL_HI 30
`define ISP_CFG_PCONN 31
`define ISP_CFG_RESET 32'h0020_0820

// Event register bits.
`define ISP_EV_TX 0
`define ISP_EV_RX 1
`define ISP_EV_RUN 2

// Reference clock derived from the system clock by a rate accumulator.
`define ISP_MCLK_MHZ 100
`define ISP_REF_MHZ 32

`endif

// ### rtl/isp_pkg.sv
/*
 Types and shared decoding of the serial audio port.
 Assumes the constants header sits beside it in rtl/.
*/
`include "isp_defs.svh"

package isp_pkg;

   // Sample width code held in the configuration register.
   typedef enum logic [1:0] {ISP_W8, ISP_W16, ISP_W24, ISP_WBAD} isp_width_t;

   // Run state of the port between start and stop tasks.
   typedef enum logic {ISP_IDLE, ISP_RUN} isp_state_t;

   // Bits per sample; an illegal code falls back to 8 bits.
   function automatic logic [5:0] isp_bits(input isp_width_t w);
      unique case (w)
         ISP_W16: isp_bits = 6'h10;
         ISP_W24: isp_bits = 6'h18;
         default: isp_bits = 6'h08;
      endcase
   endfunction

   // Samples packed in one 32-bit buffer word.
   function automatic logic [2:0] isp_per_word(input isp_width_t w);
      unique case (w)
         ISP_W16: isp_per_word = 3'h2;
         ISP_W24: isp_per_word = 3'h1;
         default: isp_per_word = 3'h4;
      endcase
   endfunction

endpackage

// ### rtl/isp_serial_engine.sv
/*
 Bit engine of the audio port: shifts samples out and in, framed by the
 word-select level, clocked by one-cycle bit clock edge pulses.
 Assumes the pulses and the select level all belong to the system clock.
*/
`timescale 1ns/1ns
`default_nettype none

module isp_serial_engine
   import isp_pkg::*;
(
   input wire logic clk, // System clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic active, // Port started.
   input wire logic aligned, // Aligned format when high.
   input wire isp_width_t width, // Sample width code.
   input wire logic sck_rise, // Bit clock rising edge pulse.
   input wire logic sck_fall, // Bit clock falling edge pulse.
   input wire logic ws, // Word-select level.
   input wire logic serial_data_in, // Serial data in, already synchronised.
   input wire logic tx_en, // Transmit path enabled.
   input wire logic rx_en, // Receive path enabled.
   input wire logic [23:0] tx_left, // Left sample to send.
   input wire logic [23:0] tx_right, // Right sample to send.
   output logic serial_data_out, // Serial data out.
   output logic tx_load, // Pulse: a sample was taken for sending.
   output logic tx_right_ch, // Channel of the taken sample.
   output logic rx_done, // Pulse: a sample was received.
   output logic [23:0] rx_word, // Received sample, right aligned.
   output logic rx_right_ch // Channel of the received sample.
);

   logic [5:0] cnt; // Bit clock periods since the last select edge.
   logic ws_prev; // Select level seen at the previous falling edge.
   logic synced; // A select edge has been seen since start.
   logic [23:0] tsh; // Transmit shift register, MSB at the top.
   logic [23:0] rsh; // Receive shift register.
   logic [5:0] rpos; // Bits taken into the sample being received.
   logic rch; // Channel of the sample being received.

   // Decoding of the frame position.
   wire [5:0] bits = isp_bits(width);
   wire [5:0] delay = aligned ? 6'h00 : 6'h01;
   wire is_right = (ws != aligned);
   wire ws_edge = sck_fall && (ws != ws_prev);
   wire [5:0] next_cnt = ws_edge ? 6'h00 : ((cnt != 6'h3F) ? cnt + 6'h01 : cnt);
   wire next_synced = active && (synced || ws_edge);
   wire load = sck_fall && next_synced && (next_cnt == delay);
   wire [23:0] pick = is_right ? tx_right : tx_left;
   wire [23:0] just = pick << (6'h18 - bits);
   wire [23:0] next_tsh = load ? just : {tsh[22:0], 1'b0};
   // In I2S format the last bit of a sample is taken on the first rise
   // after the select edge, so the bit count, not the frame position,
   // decides where a received sample ends.
   wire rx_first = synced && (cnt == delay);
   wire rx_more = (rpos != 6'h00) && (rpos < bits);
   wire [5:0] next_rpos = rx_first ? 6'h01 : rpos + 6'h01;
   wire [23:0] next_rsh = {rsh[22:0], serial_data_in};
   wire [23:0] rmask = ~(24'hFFFFFF << bits);

   // Frame tracking and transmit shifting on falling edges.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 6'h3F;
         ws_prev <= 1'b0;
         synced <= 1'b0;
         tsh <= 24'h000000;
         serial_data_out <= 1'b0;
         tx_load <= 1'b0;
         tx_right_ch <= 1'b0;
      end else if (!active) begin
         // Idle: hold the line low and wait for the next start.
         cnt <= 6'h3F;
         synced <= 1'b0;
         serial_data_out <= 1'b0;
         tx_load <= 1'b0;
         // Track the idle select level so that the first toggle after a
         // start counts as an edge, and flush bits left by a cut frame.
         ws_prev <= ws;
         tsh <= 24'h000000;
      end else begin
         tx_load <= load && tx_en;
         if (sck_fall) begin
            cnt <= next_cnt;
            ws_prev <= ws;
            synced <= next_synced;
            tsh <= next_tsh;
            serial_data_out <= tx_en && next_tsh[23];
            tx_right_ch <= is_right;
         end
      end
   end

   // Receive sampling on rising edges; extra bits are dropped.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsh <= 24'h000000;
         rpos <= 6'h00;
         rch <= 1'b0;
         rx_done <= 1'b0;
         rx_word <= 24'h000000;
         rx_right_ch <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         if (!active) begin
            // A stop drops any half-received sample.
            rpos <= 6'h00;
         end else if (rx_en && sck_rise && (rx_first || rx_more)) begin
            rsh <= next_rsh;
            rpos <= next_rpos;
            if (rx_first) begin
               rch <= is_right;
            end
            if (next_rpos == bits) begin
               rx_done <= 1'b1;
               rx_word <= next_rsh & rmask;
               rx_right_ch <= rch;
            end
         end
      end
   end

endmodule

`default_nettype wire

// ### rtl/isp_audio_port.sv
/*
 Top of the two-channel serial audio port: Avalon-MM register slave,
 master clock generator, master bit and select clock generator, slave
 clock synchronisers, zero-frame preamble and buffer word counting.
 Assumes one 100 MHz system clock; pins of the far side are asynchronous.
*/
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module isp_audio_port
   import isp_pkg::*;
#(
   parameter int MCK_PINS = 4 // Pins that may carry the master clock.
)
(
   input wire logic MCLK, // System clock, 100 MHz.
   input wire logic RESET_N, // Asynchronous reset, active low.
   input wire logic [3:0] AVS_ADDRESS, // Word address.
   input wire logic AVS_READ, // Read request.
   input wire logic AVS_WRITE, // Write request.
   input wire logic [31:0] AVS_WRITEDATA, // Write data.
   output logic [31:0] AVS_READDATA, // Read data.
   output logic AVS_WAITREQUEST, // Slave not ready.
   input wire logic SCK_IN, // Bit clock pin level.
   output logic SCK_OUT, // Bit clock drive value.
   output logic SCK_OE, // Bit clock drive enable.
   input wire logic WS_IN, // Word-select pin level.
   output logic WS_OUT, // Word-select drive value.
   output logic WS_OE, // Word-select drive enable.
   input wire logic SERIAL_DATA_IN, // Serial data in.
   output logic SERIAL_DATA_OUT, // Serial data out.
   output logic [MCK_PINS-1:0] MCK_PIN, // Master clock on selected pin.
   output logic TX_PTR_UPD, // Pulse: transmit buffer words done.
   output logic RX_PTR_UPD // Pulse: receive buffer words done.
);

   // Configuration and data registers.
   logic [31:0] cfg; // Configuration word.
   logic [13:0] maxcnt; // Buffer size in words.
   logic [23:0] tx_left; // Left transmit sample.
   logic [23:0] tx_right; // Right transmit sample.
   logic [23:0] rx_left; // Last received left sample.
   logic [23:0] rx_right; // Last received right sample.
   logic [1:0] ev; // Sticky pointer-update flags.
   isp_state_t state; // Run state.

   // Field decode of the configuration word.
   wire tx_en = cfg[`ISP_CFG_TXEN];
   wire rx_en = cfg[`ISP_CFG_RXEN];
   wire mck_en = cfg[`ISP_CFG_MCKEN];
   wire master = cfg[`ISP_CFG_MASTER];
   wire aligned = cfg[`ISP_CFG_ALIGNED];
   wire isp_width_t width = isp_width_t'(cfg[`ISP_CFG_WIDTH_HI:`ISP_CFG_WIDTH_LO]);
   wire [7:0] div = cfg[`ISP_CFG_DIV_HI:`ISP_CFG_DIV_LO];
   wire [11:0] ratio = cfg[`ISP_CFG_RATIO_HI:`ISP_CFG_RATIO_LO];
   wire [2:0] psel = cfg[`ISP_CFG_PSEL_HI:`ISP_CFG_PSEL_LO];
   wire pconn = cfg[`ISP_CFG_PCONN];
   wire [5:0] bits = isp_bits(width);
   wire running = (state == ISP_RUN);

   // Bus decode: a request is taken while waitrequest is low.
   wire req = AVS_READ || AVS_WRITE;
   wire wr_take = AVS_WRITE && !AVS_WAITREQUEST;
   wire wr_tasks = wr_take && (AVS_ADDRESS == `ISP_OFS_TASKS);
   wire start_task = wr_tasks && AVS_WRITEDATA[`ISP_TASK_START];
   wire stop_task = wr_tasks && AVS_WRITEDATA[`ISP_TASK_STOP];
   wire wr_ev = wr_take && (AVS_ADDRESS == `ISP_OFS_EVENTS);
   wire [1:0] ev_clr = wr_ev ? AVS_WRITEDATA[1:0] : 2'h0;

   // Read multiplexer; unmapped addresses read as zero.
   logic [31:0] rd_mux;
   always_comb begin
      unique case (AVS_ADDRESS)
         `ISP_OFS_CONFIG: rd_mux = cfg;
         `ISP_OFS_MAXCNT: rd_mux = {18'h00000, maxcnt};
         `ISP_OFS_TXLEFT: rd_mux = {8'h00, tx_left};
         `ISP_OFS_TXRIGHT: rd_mux = {8'h00, tx_right};
         `ISP_OFS_RXLEFT: rd_mux = {8'h00, rx_left};
         `ISP_OFS_RXRIGHT: rd_mux = {8'h00, rx_right};
         `ISP_OFS_EVENTS: rd_mux = {29'h00000000, running, ev};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // One wait cycle per access: the answer stands one edge after the request.
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA <= 32'h00000000;
      end else begin
         AVS_WAITREQUEST <= !(req && AVS_WAITREQUEST);
         if (AVS_READ && AVS_WAITREQUEST) begin
            AVS_READDATA <= rd_mux;
         end
      end
   end

   // Software-written registers.
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cfg <= `ISP_CFG_RESET;
         maxcnt <= 14'h0001;
         tx_left <= 24'h000000;
         tx_right <= 24'h000000;
      end else if (wr_take) begin
         unique case (AVS_ADDRESS)
            `ISP_OFS_CONFIG: cfg <= AVS_WRITEDATA;
            `ISP_OFS_MAXCNT: maxcnt <= AVS_WRITEDATA[13:0];
            `ISP_OFS_TXLEFT: tx_left <= AVS_WRITEDATA[23:0];
            `ISP_OFS_TXRIGHT: tx_right <= AVS_WRITEDATA[23:0];
            default: ;
         endcase
      end
   end

   // Start and stop tasks; a stop in the same write wins.
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state <= ISP_IDLE;
      end else if (stop_task) begin
         state <= ISP_IDLE;
      end else if (start_task) begin
         state <= ISP_RUN;
      end
   end

   // Reference tick: 32 of every 100 system cycles, spread evenly.
   localparam logic [7:0] REF_STEP = 8'(`ISP_REF_MHZ);
   localparam logic [7:0] REF_MOD = 8'(`ISP_MCLK_MHZ);
   logic [7:0] ref_acc; // Rate accumulator, one bit wider than the modulus.
   wire [7:0] ref_sum = ref_acc + REF_STEP;
   wire ref_tick = (ref_sum >= REF_MOD);
   wire mck_run = running && mck_en;
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ref_acc <= 8'h00;
      end else if (!mck_run) begin
         ref_acc <= 8'h00;
      end else begin
         ref_acc <= ref_tick ? ref_sum - REF_MOD : ref_sum;
      end
   end

   // Master clock: reference divided by the divisor, below 2 taken as 2.
   logic [7:0] mck_cnt; // Reference ticks in this period.
   logic mck_lvl; // Master clock level.
   wire [7:0] div_eff = (div < 8'h02) ? 8'h02 : div;
   wire mck_hi_end = ref_tick && (mck_cnt == (div_eff >> 1) - 8'h01);
   wire mck_lo_end = ref_tick && (mck_cnt == div_eff - 8'h01);
   wire mck_half = mck_run && (mck_hi_end || mck_lo_end);
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         mck_cnt <= 8'h00;
         mck_lvl <= 1'b0;
      end else if (!mck_run) begin
         // Stopped generator parks low so the next start is clean.
         mck_cnt <= 8'h00;
         mck_lvl <= 1'b0;
      end else if (ref_tick) begin
         mck_cnt <= mck_lo_end ? 8'h00 : mck_cnt + 8'h01;
         if (mck_lo_end) begin
            mck_lvl <= 1'b1;
         end else if (mck_hi_end) begin
            mck_lvl <= 1'b0;
         end
      end
   end

   // Master clock to the selected pin, one flop per pin.
   genvar gp;
   generate
      for (gp = 0; gp < MCK_PINS; gp++) begin : g_mck_pin
         always_ff @(posedge MCLK or negedge RESET_N) begin
            if (!RESET_N) begin
               MCK_PIN[gp] <= 1'b0;
            end else begin
               MCK_PIN[gp] <= pconn && (psel == 3'(gp)) && mck_lvl;
            end
         end
      end
   endgenerate

   // Bit clock half period: 2*width added per master half period, the
   // ratio taken off; exact because the ratio divides evenly.
   logic [12:0] sck_acc; // Bit clock phase accumulator.
   logic [5:0] bitc; // Bit clock periods into this half-frame.
   logic m_rise; // Master rising edge pulse for the engine.
   logic m_fall; // Master falling edge pulse for the engine.
   wire m_run = running && master;
   wire [12:0] sck_sum = sck_acc + {6'h00, bits, 1'b0};
   wire sck_half = m_run && mck_half && (sck_sum >= {1'b0, ratio});
   wire half_end = (bitc == bits - 6'h01);

   // Master clocks: bit clock from the master clock, select from bit count.
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sck_acc <= 13'h0000;
         bitc <= 6'h00;
         SCK_OUT <= 1'b1;
         WS_OUT <= 1'b0;
         m_rise <= 1'b0;
         m_fall <= 1'b0;
      end else if (!m_run) begin
         // Preset so that the first falling edge opens a left half.
         sck_acc <= 13'h0000;
         bitc <= bits - 6'h01;
         SCK_OUT <= 1'b1;
         WS_OUT <= !aligned;
         m_rise <= 1'b0;
         m_fall <= 1'b0;
      end else begin
         m_rise <= sck_half && !SCK_OUT;
         m_fall <= sck_half && SCK_OUT;
         if (mck_half) begin
            sck_acc <= sck_half ? sck_sum - {1'b0, ratio} : sck_sum;
         end
         if (sck_half) begin
            SCK_OUT <= !SCK_OUT;
            if (SCK_OUT) begin
               bitc <= half_end ? 6'h00 : bitc + 6'h01;
               if (half_end) begin
                  WS_OUT <= !WS_OUT;
               end
            end
         end
      end
   end

   // Clocks are driven only by a running master.
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         SCK_OE <= 1'b0;
         WS_OE <= 1'b0;
      end else begin
         SCK_OE <= m_run;
         WS_OE <= m_run;
      end
   end

   // Pin synchronisers; only the second stage and later are read.
   logic [2:0] sy1; // First stage: bit clock, select, data.
   logic [2:0] sy2; // Second stage.
   logic sck_d; // Bit clock one cycle later, for edges.
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sy1 <= 3'h0;
         sy2 <= 3'h0;
         sck_d <= 1'b0;
      end else begin
         sy1 <= {SCK_IN, WS_IN, SERIAL_DATA_IN};
         sy2 <= sy1;
         sck_d <= sy2[2];
      end
   end

   // In slave mode the framing comes from the pins alone.
   wire e_rise = master ? m_rise : (sy2[2] && !sck_d);
   wire e_fall = master ? m_fall : (!sy2[2] && sck_d);
   wire e_ws = master ? WS_OUT : sy2[1];

   // Zero preamble: two whole frames of silence after a master start.
   logic [1:0] zcnt; // Zero frames still to send.
   logic e_tx_load; // Engine took a sample.
   logic e_tx_right; // Channel of that sample.
   wire zeroing = (zcnt != 2'h0);
   wire [23:0] send_l = zeroing ? 24'h000000 : tx_left;
   wire [23:0] send_r = zeroing ? 24'h000000 : tx_right;
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         zcnt <= 2'h0;
      end else if (start_task && !stop_task) begin
         zcnt <= master ? 2'h2 : 2'h0;
      end else if (e_tx_load && e_tx_right && zeroing) begin
         zcnt <= zcnt - 2'h1;
      end
   end

   // Bit engine.
   logic e_rx_done;
   logic [23:0] e_rx_word;
   logic e_rx_right;
   isp_serial_engine u_engine (
      .clk(MCLK),
      .rst_n(RESET_N),
      .active(running),
      .aligned(aligned),
      .width(width),
      .sck_rise(e_rise),
      .sck_fall(e_fall),
      .ws(e_ws),
      .serial_data_in(sy2[0]),
      .tx_en(tx_en),
      .rx_en(rx_en),
      .tx_left(send_l),
      .tx_right(send_r),
      .serial_data_out(SERIAL_DATA_OUT),
      .tx_load(e_tx_load),
      .tx_right_ch(e_tx_right),
      .rx_done(e_rx_done),
      .rx_word(e_rx_word),
      .rx_right_ch(e_rx_right)
   );

   // Received samples are kept per channel for software.
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rx_left <= 24'h000000;
         rx_right <= 24'h000000;
      end else if (e_rx_done) begin
         if (e_rx_right) begin
            rx_right <= e_rx_word;
         end else begin
            rx_left <= e_rx_word;
         end
      end
   end

   // Buffer word counting, path 0 transmit and path 1 receive. Zero
   // preamble samples come from no buffer and are not counted.
   wire [1:0] samp_done = {e_rx_done, e_tx_load && !zeroing};
   wire [2:0] per_word = isp_per_word(width);
   logic [1:0] ptr_pulse; // Word count reached, per path.
   genvar gw;
   generate
      for (gw = 0; gw < 2; gw++) begin : g_words
         logic [2:0] scnt; // Samples in the current word.
         logic [13:0] wcnt; // Words since the last event.
         wire word_end = samp_done[gw] && (scnt == per_word - 3'h1);
         wire buf_end = word_end && (wcnt >= maxcnt - 14'h0001);
         always_ff @(posedge MCLK or negedge RESET_N) begin
            if (!RESET_N) begin
               scnt <= 3'h0;
               wcnt <= 14'h0000;
               ptr_pulse[gw] <= 1'b0;
            end else if (start_task) begin
               scnt <= 3'h0;
               wcnt <= 14'h0000;
               ptr_pulse[gw] <= 1'b0;
            end else begin
               ptr_pulse[gw] <= buf_end;
               if (samp_done[gw]) begin
                  scnt <= word_end ? 3'h0 : scnt + 3'h1;
               end
               if (word_end) begin
                  wcnt <= buf_end ? 14'h0000 : wcnt + 14'h0001;
               end
            end
         end
         // Sticky flag: a new event beats a clear in the same cycle.
         always_ff @(posedge MCLK or negedge RESET_N) begin
            if (!RESET_N) begin
               ev[gw] <= 1'b0;
            end else begin
               ev[gw] <= (ev[gw] && !ev_clr[gw]) || ptr_pulse[gw];
            end
         end
      end
   endgenerate

   // Event pulses leave on their own flops.
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         TX_PTR_UPD <= 1'b0;
         RX_PTR_UPD <= 1'b0;
      end else begin
         TX_PTR_UPD <= ptr_pulse[0];
         RX_PTR_UPD <= ptr_pulse[1];
      end
   end

endmodule

`default_nettype wire

// ### testbench/isp_audio_port_properties.sv
/* Checker of the audio port pins.
   Assumes it is bound into isp_audio_port. */
`timescale 1ns/1ns
`default_nettype none
module isp_chk #(parameter int MCK_PINS = 4) (
   input wire logic MCLK, // Clock.
   input wire logic RESET_N, // Reset, active low.
   input wire logic AVS_READ, // Read.
   input wire logic AVS_WRITE, // Write.
   input wire logic [31:0] AVS_READDATA, // Read data.
   input wire logic AVS_WAITREQUEST, // Wait.
   input wire logic SCK_OUT, // Bit clock.
   input wire logic SCK_OE, // Bit clock enable.
   input wire logic WS_OUT, // Select.
   input wire logic WS_OE, // Select enable.
   input wire logic SERIAL_DATA_OUT, // Data out.
   input wire logic [MCK_PINS-1:0] MCK_PIN, // Master clock pins.
   input wire logic TX_PTR_UPD, // Transmit event.
   input wire logic RX_PTR_UPD // Receive event.
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESET_N);
   chk_both_driven: assert property (WS_OE == SCK_OE) else $error("clock drives differ");
   chk_ws_on_fall: assert property (WS_OE && $past(WS_OE) && $changed(WS_OUT) |->
      $fell(SCK_OUT)) else $error("select moved off a fall");
   chk_sd_after_fall: assert property (SCK_OE && $past(SCK_OE) && $changed(SERIAL_DATA_OUT) |->
      $past(SCK_OUT, 2) && !$past(SCK_OUT)) else $error("data moved off a fall");
   chk_wait_one: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=>
      !AVS_WAITREQUEST) else $error("no answer in one cycle");
   chk_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST) else $error("long answer");
   chk_rd_hold: assert property ($changed(AVS_READDATA) |-> !AVS_WAITREQUEST && $past(AVS_READ))
      else $error("read data moved");
   chk_tx_event: assert property (TX_PTR_UPD |=> !TX_PTR_UPD) else $error("long tx event");
   chk_rx_event: assert property (RX_PTR_UPD |=> !RX_PTR_UPD) else $error("long rx event");
   chk_one_pin: assert property ($onehot0(MCK_PIN)) else $error("two clock pins");
endmodule
bind isp_audio_port isp_chk #(.MCK_PINS(MCK_PINS)) u_isp_chk (.MCLK(MCLK), .RESET_N(RESET_N),
   .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE), .WS_OUT(WS_OUT),
   .WS_OE(WS_OE), .SERIAL_DATA_OUT(SERIAL_DATA_OUT), .MCK_PIN(MCK_PIN), .TX_PTR_UPD(TX_PTR_UPD),
   .RX_PTR_UPD(RX_PTR_UPD));
`default_nettype wire

// ### testbench/isp_codec_model.sv
/* Far-side codec returning two fixed samples.
   Assumes the port is master of both clocks. */
`timescale 1ns/1ns
`default_nettype none
module isp_codec_model (
   input wire logic sck, // Bit clock, only received.
   input wire logic ws, // Select, only received.
   input wire logic oe, // Clocks driven.
   input wire logic aligned, // Aligned format.
   input wire logic [23:0] left_j, // Left, MSB at bit 23.
   input wire logic [23:0] right_j, // Right, MSB at bit 23.
   output logic sd // Data to the port.
);
   logic wp = 1'b0; // Select at the last fall.
   int n = 0; // Falls since the select edge.
   logic [23:0] sh = 24'h0; // Shift register.
   // Wait 1 ns after a fall so the select has settled.
   always @(negedge sck) begin
      #1;
      n = (ws != wp) ? 0 : n + 1;
      wp = ws;
      if (n == int'(!aligned)) sh = (ws ^ aligned) ? right_j : left_j;
      sd = sh[23];
      sh = sh << 1;
   end
   // Take the idle select level when the clocks start, so the first toggle is an edge.
   always @(posedge oe) wp = ws;
   // A released line shows the inverse of its last bit.
   always @(negedge oe) sd = ~sd;
   initial sd = 1'b0;
endmodule
`default_nettype wire

// ### testbench/tb.sv
/* Bench of the audio port as master in both formats.
   Assumes the codec model on the far side. */
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic MCLK = 0, RESET_N = 0, AVS_READ = 0, AVS_WRITE = 0, fmt = 0;
   logic [3:0] AVS_ADDRESS = 4'h0, MCK_PIN;
   logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, rd;
   logic AVS_WAITREQUEST, SCK_OUT, SCK_OE, WS_OUT, WS_OE, SERIAL_DATA_IN, SERIAL_DATA_OUT, TX_PTR_UPD, RX_PTR_UPD;
   logic [95:0] sh;
   int error_cnt = 0, num_checks = 0, cyc = 0;
   always #5 MCLK = ~MCLK;
   isp_audio_port u_isp_audio_port (.MCLK(MCLK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS),
      .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .SCK_IN(SCK_OUT),
      .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE), .WS_IN(WS_OUT), .WS_OUT(WS_OUT), .WS_OE(WS_OE),
      .SERIAL_DATA_IN(SERIAL_DATA_IN), .SERIAL_DATA_OUT(SERIAL_DATA_OUT), .MCK_PIN(MCK_PIN), .TX_PTR_UPD(TX_PTR_UPD),
      .RX_PTR_UPD(RX_PTR_UPD));
   isp_codec_model u_isp_codec_model (.sck(SCK_OUT), .ws(WS_OUT), .oe(SCK_OE), .aligned(fmt),
      .left_j(24'hC3_0000), .right_j(24'h5A_0000), .sd(SERIAL_DATA_IN));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("errors=%0d checks=%0d", error_cnt, num_checks);
      if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // One bus access; held until waitrequest is seen low at an edge.
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge MCLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= w;
      AVS_READ <= !w;
      do @(posedge MCLK); while (AVS_WAITREQUEST !== 1'b0);
      rd = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
   endtask
   // Reset values, an unmapped word and a read-only word.
   task automatic t_regs;
      bus(0, 4'h1, 0); check(rd, 32'h0020_0820);
      bus(0, 4'h2, 0); check(rd, 32'h0000_0001);
      bus(1, 4'h8, 32'hFFFF_FFFF); bus(0, 4'h8, 0); check(rd, 32'h0);
      bus(1, 4'h5, 32'hFF); bus(0, 4'h5, 0); check(rd, 32'h0);
   endtask
   // Master run, width code w, ratio twice the width, divisor 2, clock on pin 1.
   task automatic t_stream(input logic a, input logic [1:0] w);
      int nb;
      logic [31:0] cfg_w;
      nb = 8 << w;
      cfg_w = {4'h9, 12'(2 * nb), 9'h004, w, a, 4'hF};
      fmt = a;
      sh = '0;
      bus(1, 4'h3, 32'hA5); bus(1, 4'h4, 32'h3C);
      bus(1, 4'h1, cfg_w);
      check({31'h0, SCK_OE}, 32'h0);
      bus(1, 4'h0, 32'h1);
      do @(posedge MCLK); while (WS_OUT !== a);
      repeat (int'(!a)) @(posedge SCK_OUT);
      repeat (6 * nb) begin
         @(posedge SCK_OUT);
         sh = {sh[94:0], SERIAL_DATA_OUT};
      end
      check(32'(sh >> (4 * nb)), 32'h0);
      check(32'(sh >> (2 * nb)), 32'h0);
      check(32'(sh), (32'hA5 << nb) | 32'h3C);
      @(posedge MCK_PIN[1]); check({28'h0, MCK_PIN}, 32'h2);
      repeat (300) @(posedge MCLK);
      bus(0, 4'h5, 0); check(rd, 32'hC3 << (nb - 8));
      bus(0, 4'h6, 0); check(rd, 32'h5A << (nb - 8));
      bus(0, 4'h7, 0); check(rd, 32'h7);
      bus(1, 4'h0, 32'h2);
      repeat (4) @(posedge MCLK);
      check({27'h0, SCK_OE, MCK_PIN}, 32'h0);
      bus(1, 4'h7, 32'h3);
   endtask
   initial begin
      repeat (20) @(posedge MCLK);
      RESET_N <= 1'b1;
      t_regs;
      t_stream(1'b0, 2'h0);
      t_stream(1'b1, 2'h1);
      test_done;
   end
   // A hang counts as a mismatch.
   always @(posedge MCLK) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         test_done;
      end
   end
endmodule
`default_nettype wire
